/* rtl/tcml_channel.sv */
// Local design decisions: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ns
// Notes on behaviour
// - Dual 8-bit: upper byte drops once per full lower countdown plus one.
// - Lower byte zero: upper holds, next clock lower reloads and upper decrements.
// - Dual continuous: output low until upper zero, high until both zero, low at expiry.
// - Dual with zero lower preset: expiry every upper preset plus one, output toggles.
// - Both presets zero: counter unchanged, output toggles every count clock.
// - Synthesis init: timer reset, gate fall, or preset write when sub-select clear.
// - Counting and counter reads do not depend on the output enable.
// - Mode decode from measure, sub-select and variant bits.
// - Single-shot: output low after first expiry until next init or control write.
// - Single-shot: counter keeps cycling; each expiry sets flag and reloads.
// - Single-shot: counting does not need the gate held low.
// - Single-shot zero presets: output low on first clock; expiries every clock.
// - Measurement: flag from expiry and gate edges; init depends on flag.
// - Measurement: output low after init, high at first expiry, then toggles.
// - Measurement still uses 16-bit or dual 8-bit counting by split bit.
// - Frequency, variant 1: expiry before gate fall sets flag, stops counter.
// - Frequency, variant 0: gate fall first sets flag; expiry first inhibits flags.
// - Frequency: gate fall enables and inits; counting stops on flag, preset write, reset.
// - Frequency, variant 1: gate fall before expiry restarts silently.
// - Pulse width: gate rise stops count; flag if low time short (0) or long (1).
// - Timer reset is reset bit set or external reset input low.
// - Expiry is a count step taken with the counter already at all zeros.
module tcml_channel (
  // Clock and reset
  input  wire logic                   mclk,
  input  wire logic                   sys_rst,
  // Register bus
  input  wire tcml_pkg::tcml_axi_req_t axiReq,
  output      tcml_pkg::tcml_axi_rsp_t axiRsp,
  // Channel pins
  input  wire logic                   gatePin,
  input  wire logic                   countClkPin,
  input  wire logic                   extReset_n,
  // Channel outputs
  output      logic                   channelOutput,
  output      logic                   channelFlag
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic [2:0]           gateSync;
    logic [2:0]           clkSync;
    logic [1:0]           rstSync;
    tcml_pkg::tcml_ctrl_t ctrl;
    logic [15:0]          preset;
    logic [15:0]          counter;
    logic                 flag;
    logic                 inhibit;
    logic                 ce;
    logic                 outLvl;
    logic                 shotDone;
    logic                 outPin;
    logic                 awHeld;
    logic [3:0]           awAddr;
    logic                 wHeld;
    logic [31:0]          wData;
    logic [3:0]           wStrb;
    tcml_pkg::tcml_axi_rsp_t rsp;
  } tcml_state_t;

  tcml_state_t st;
  tcml_state_t next_st;

  // ****************************************************************
  // Functions
  // ****************************************************************
  // Mode decode from the three mode bits
  function automatic tcml_pkg::tcml_mode_t decodeMode(input tcml_pkg::tcml_ctrl_t c);
    tcml_pkg::tcml_mode_t m;
    m = tcml_pkg::MODE_CONT;
    if (c.measureModeSelect) begin
      m = c.modeSubSelect ? tcml_pkg::MODE_PULSE : tcml_pkg::MODE_FREQ;
    end else begin
      m = c.modeVariantSelect ? tcml_pkg::MODE_SHOT : tcml_pkg::MODE_CONT;
    end
    return m;
  endfunction

  // One count step; bit 16 is the expiry
  function automatic logic [16:0] stepCount(input logic [15:0] cnt,
                                            input logic [15:0] pre,
                                            input logic        split);
    logic [16:0] r;
    r = {1'b0, cnt};
    if (cnt == 16'h0000) begin
      r = {1'b1, pre};
    end else if (!split) begin
      r = {1'b0, cnt - 16'h0001};
    end else if (cnt[7:0] == 8'h00) begin
      r = {1'b0, cnt[15:8] - 8'h01, pre[7:0]};
    end else begin
      r = {1'b0, cnt[15:8], cnt[7:0] - 8'h01};
    end
    return r;
  endfunction

  // Read data mux, zero for unmapped
  function automatic logic [31:0] readWord(input tcml_state_t s, input logic [3:0] a);
    logic [31:0] d;
    d = 32'h0000_0000;
    unique case (a)
      tcml_pkg::ADDR_CTRL: begin
        d[tcml_pkg::CTRL_RESET_POS]   = s.ctrl.channelResetBit;
        d[tcml_pkg::CTRL_SPLIT_POS]   = s.ctrl.counterSplitSelect;
        d[tcml_pkg::CTRL_MEASURE_POS] = s.ctrl.measureModeSelect;
        d[tcml_pkg::CTRL_SUB_POS]     = s.ctrl.modeSubSelect;
        d[tcml_pkg::CTRL_VARIANT_POS] = s.ctrl.modeVariantSelect;
        d[tcml_pkg::CTRL_OUTEN_POS]   = s.ctrl.outputDriveEnable;
      end
      tcml_pkg::ADDR_PRESET:  d[15:0] = s.preset;
      tcml_pkg::ADDR_COUNTER: d[15:0] = s.counter;
      tcml_pkg::ADDR_STATUS: begin
        d[tcml_pkg::STAT_FLAG_POS]    = s.flag;
        d[tcml_pkg::STAT_OUT_POS]     = s.outLvl;
        d[tcml_pkg::STAT_CE_POS]      = s.ce;
        d[tcml_pkg::STAT_INHIBIT_POS] = s.inhibit;
      end
      default: d = 32'h0000_0000;
    endcase
    return d;
  endfunction

  // ****************************************************************
  // Next state
  // ****************************************************************
  // Bus slave, synchronisers and channel logic in one pass
  always_comb begin
    logic                 wrCtrl;
    logic                 wrPreset;
    logic                 clrFlag;
    logic                 mapped;
    logic                 gateLow;
    logic                 gateFall;
    logic                 gateRise;
    logic                 tick;
    logic                 timerReset;
    logic                 doInit;
    logic                 doStep;
    logic                 setFlag;
    logic                 expiry;
    logic [16:0]          stepped;
    tcml_pkg::tcml_mode_t mode;
    gateLow    = !st.gateSync[1];
    gateFall   = !st.gateSync[1] && st.gateSync[2];
    gateRise   = st.gateSync[1] && !st.gateSync[2];
    tick       = st.clkSync[1] && !st.clkSync[2];
    timerReset = 1'b0;
    mode       = tcml_pkg::MODE_CONT;
    wrCtrl     = 1'b0;
    wrPreset   = 1'b0;
    clrFlag    = 1'b0;
    mapped     = 1'b0;
    doInit     = 1'b0;
    doStep     = 1'b0;
    setFlag    = 1'b0;
    expiry     = 1'b0;
    stepped    = 17'h0_0000;
    next_st    = st;

    // Pins pass two stages; edge logic reads only the second and third
    next_st.gateSync = {st.gateSync[1:0], gatePin};
    next_st.clkSync  = {st.clkSync[1:0], countClkPin};
    next_st.rstSync  = {st.rstSync[0], extReset_n};

    // Write channels: each held until both present
    if (axiReq.awvalid && st.rsp.awready) begin
      next_st.awHeld = 1'b1;
      next_st.awAddr = axiReq.awaddr[3:0];
    end
    if (axiReq.wvalid && st.rsp.wready) begin
      next_st.wHeld = 1'b1;
      next_st.wData = axiReq.wdata;
      next_st.wStrb = axiReq.wstrb;
    end
    if (st.rsp.bvalid && axiReq.bready) begin
      next_st.rsp.bvalid = 1'b0;
    end
    if (st.awHeld && st.wHeld && !st.rsp.bvalid) begin
      next_st.awHeld     = 1'b0;
      next_st.wHeld      = 1'b0;
      next_st.rsp.bvalid = 1'b1;
      mapped = st.awAddr[1:0] == 2'h0;
      wrCtrl   = mapped && st.awAddr == tcml_pkg::ADDR_CTRL && st.wStrb[0];
      wrPreset = mapped && st.awAddr == tcml_pkg::ADDR_PRESET && |st.wStrb[1:0];
      clrFlag  = mapped && st.awAddr == tcml_pkg::ADDR_STATUS && st.wStrb[0]
                 && st.wData[tcml_pkg::STAT_FLAG_POS];
      // Every aligned word answers OKAY; counter writes are dropped
      next_st.rsp.bresp = mapped ? tcml_pkg::RESP_OKAY : tcml_pkg::RESP_SLVERR;
    end
    if (wrCtrl) begin
      next_st.ctrl.channelResetBit    = st.wData[tcml_pkg::CTRL_RESET_POS];
      next_st.ctrl.counterSplitSelect = st.wData[tcml_pkg::CTRL_SPLIT_POS];
      next_st.ctrl.measureModeSelect  = st.wData[tcml_pkg::CTRL_MEASURE_POS];
      next_st.ctrl.modeSubSelect      = st.wData[tcml_pkg::CTRL_SUB_POS];
      next_st.ctrl.modeVariantSelect  = st.wData[tcml_pkg::CTRL_VARIANT_POS];
      next_st.ctrl.outputDriveEnable  = st.wData[tcml_pkg::CTRL_OUTEN_POS];
      next_st.shotDone = 1'b0;
    end
    if (wrPreset) begin
      if (st.wStrb[0]) begin
        next_st.preset[7:0] = st.wData[7:0];
      end
      if (st.wStrb[1]) begin
        next_st.preset[15:8] = st.wData[15:8];
      end
    end
    next_st.rsp.awready = !next_st.awHeld && !next_st.rsp.bvalid;
    next_st.rsp.wready  = !next_st.wHeld && !next_st.rsp.bvalid;

    // Read channel: one read at a time
    if (st.rsp.rvalid && axiReq.rready) begin
      next_st.rsp.rvalid = 1'b0;
    end
    if (axiReq.arvalid && st.rsp.arready) begin
      next_st.rsp.rvalid = 1'b1;
      next_st.rsp.rdata  = readWord(st, axiReq.araddr[3:0]);
      next_st.rsp.rresp  = (axiReq.araddr[1:0] == 2'h0)
                           ? tcml_pkg::RESP_OKAY : tcml_pkg::RESP_SLVERR;
    end
    next_st.rsp.arready = !next_st.rsp.rvalid;

    // Channel timing uses the freshly written control and preset
    mode       = decodeMode(next_st.ctrl);
    timerReset = next_st.ctrl.channelResetBit || !st.rstSync[1];
    stepped    = stepCount(st.counter, next_st.preset, next_st.ctrl.counterSplitSelect);

    if (timerReset) begin
      doInit          = 1'b1;
      next_st.ce      = 1'b0;
      next_st.inhibit = 1'b0;
    end else begin
      unique case (mode)
        tcml_pkg::MODE_CONT,
        tcml_pkg::MODE_SHOT: begin
          doInit = gateFall || (wrPreset && !next_st.ctrl.modeSubSelect);
          // Continuous needs the gate low, single-shot does not
          doStep = !doInit && tick
                   && (mode == tcml_pkg::MODE_SHOT || gateLow);
        end
        tcml_pkg::MODE_FREQ: begin
          if (wrPreset) begin
            next_st.ce = 1'b0;
          end else if (gateFall && !st.flag) begin
            if (st.ce && !st.inhibit && !next_st.ctrl.modeVariantSelect) begin
              setFlag    = 1'b1;
              next_st.ce = 1'b0;
            end else begin
              doInit     = 1'b1;
              next_st.ce = 1'b1;
            end
          end else begin
            doStep = tick && st.ce;
          end
        end
        tcml_pkg::MODE_PULSE: begin
          if (wrPreset) begin
            next_st.ce = 1'b0;
          end else if (gateFall && !st.flag) begin
            doInit     = 1'b1;
            next_st.ce = 1'b1;
          end else if (gateRise && st.ce) begin
            next_st.ce = 1'b0;
            setFlag    = !st.inhibit && !next_st.ctrl.modeVariantSelect;
          end else begin
            doStep = tick && st.ce;
          end
        end
      endcase
    end

    // Load from preset on initialisation
    if (doInit) begin
      next_st.counter  = next_st.preset;
      next_st.outLvl   = 1'b0;
      next_st.shotDone = 1'b0;
      next_st.inhibit  = 1'b0;
    end

    // Count step, expiry effects and output shaping
    if (doStep) begin
      expiry          = stepped[16];
      next_st.counter = stepped[15:0];
      unique case (mode)
        tcml_pkg::MODE_CONT,
        tcml_pkg::MODE_SHOT: begin
          setFlag = expiry;
          if (!next_st.ctrl.counterSplitSelect) begin
            next_st.outLvl = expiry ? !st.outLvl : st.outLvl;
            if (mode == tcml_pkg::MODE_SHOT) begin
              next_st.outLvl = !expiry && !st.shotDone;
            end
          end else if (next_st.preset[7:0] == 8'h00) begin
            next_st.outLvl = expiry ? !st.outLvl : st.outLvl;
          end else begin
            // Rises one clock after the upper byte is spent, falls at expiry
            next_st.outLvl = !expiry && st.counter[15:8] == 8'h00;
          end
          if (mode == tcml_pkg::MODE_SHOT && (expiry || st.shotDone)) begin
            next_st.shotDone = 1'b1;
            next_st.outLvl   = 1'b0;
          end
        end
        tcml_pkg::MODE_FREQ,
        tcml_pkg::MODE_PULSE: begin
          next_st.outLvl = expiry ? !st.outLvl : st.outLvl;
          if (expiry) begin
            if (mode == tcml_pkg::MODE_FREQ && next_st.ctrl.modeVariantSelect) begin
              setFlag    = !st.inhibit;
              next_st.ce = 1'b0;
            end else if (mode == tcml_pkg::MODE_PULSE && next_st.ctrl.modeVariantSelect) begin
              setFlag    = !st.inhibit;
              next_st.ce = 1'b0;
            end
            next_st.inhibit = 1'b1;
          end
        end
      endcase
    end

    // A flag raised in measurement modes also stops the counter
    if (setFlag && next_st.ctrl.measureModeSelect) begin
      next_st.ce = 1'b0;
    end

    // Set wins over a software clear in the same cycle
    if (setFlag) begin
      next_st.flag = 1'b1;
    end else if (clrFlag) begin
      next_st.flag = 1'b0;
    end

    // Pin follows level only when enabled; counting is unaffected
    next_st.outPin = next_st.outLvl && next_st.ctrl.outputDriveEnable;
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  // Synchronous reset; gate synchroniser starts high like its pin, the count clock and external reset ones start low
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      st             <= '0;
      st.gateSync    <= 3'h7;
      st.clkSync     <= 3'h0;
      st.rstSync     <= 2'h0;
      st.preset      <= tcml_pkg::PRESET_RESET;
      st.counter     <= tcml_pkg::COUNT_RESET;
      st.rsp.awready <= 1'b1;
      st.rsp.wready  <= 1'b1;
      st.rsp.arready <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign axiRsp        = st.rsp;
  assign channelOutput = st.outPin;
  assign channelFlag   = st.flag;

endmodule

/* rtl/tcml_pkg.sv */
package tcml_pkg;

  // ****************************************************************
  // Register map (byte addresses, one aligned word each)
  // ****************************************************************
  localparam logic [3:0] ADDR_CTRL    = 4'h0;
  localparam logic [3:0] ADDR_PRESET  = 4'h4;
  localparam logic [3:0] ADDR_COUNTER = 4'h8;
  localparam logic [3:0] ADDR_STATUS  = 4'hc;

  // ****************************************************************
  // Control field positions
  // ****************************************************************
  localparam int CTRL_RESET_POS   = 0;
  localparam int CTRL_SPLIT_POS   = 2;
  localparam int CTRL_MEASURE_POS = 3;
  localparam int CTRL_SUB_POS     = 4;
  localparam int CTRL_VARIANT_POS = 5;
  localparam int CTRL_OUTEN_POS   = 7;

  // Status field positions
  localparam int STAT_FLAG_POS    = 0;
  localparam int STAT_OUT_POS     = 1;
  localparam int STAT_CE_POS      = 2;
  localparam int STAT_INHIBIT_POS = 3;

  // Reset values
  localparam logic [15:0] PRESET_RESET = 16'h0000;
  localparam logic [15:0] COUNT_RESET  = 16'h0000;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [1:0] {
    MODE_CONT,
    MODE_SHOT,
    MODE_FREQ,
    MODE_PULSE
  } tcml_mode_t;

  typedef struct packed {
    logic outputDriveEnable;
    logic modeVariantSelect;
    logic modeSubSelect;
    logic measureModeSelect;
    logic counterSplitSelect;
    logic channelResetBit;
  } tcml_ctrl_t;

  typedef struct packed {
    logic        awvalid;
    logic [31:0] awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [31:0] araddr;
    logic        rready;
  } tcml_axi_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } tcml_axi_rsp_t;

endpackage

/* bench/tcml_channel_asserts.sv */
`timescale 1ns/1ns
module tcml_channel_asserts (
  // Clock and reset
  input wire logic                    mclk,
  input wire logic                    sys_rst,
  // Register bus
  input wire tcml_pkg::tcml_axi_req_t axiReq,
  input wire tcml_pkg::tcml_axi_rsp_t axiRsp,
  // Channel pins
  input wire logic                    gatePin,
  input wire logic                    countClkPin,
  input wire logic                    extReset_n,
  input wire logic                    channelOutput,
  input wire logic                    channelFlag
);
  // ******
  // Clocking and helpers
  // ******
  default clocking @(posedge mclk);
  endclocking
  default disable iff (sys_rst);

  // Alignment bits kept apart so they can be looked back on
  logic [1:0] arLow;
  assign arLow = axiReq.araddr[1:0];

  // Address and data of a write taken at one edge
  sequence wrTaken;
    axiReq.awvalid && axiRsp.awready && axiReq.wvalid && axiRsp.wready;
  endsequence
  // External reset held long enough to pass both sync flops
  sequence extLow;
    !extReset_n [*6];
  endsequence

  // ******
  // Checks
  // ******
  a_reset_quiet: assert property ($fell(sys_rst) |-> !channelOutput && !channelFlag)
    else $error("output or flag set after reset");
  a_write_answer: assert property (wrTaken |-> ##2 axiRsp.bvalid)
    else $error("write response late");
  a_read_answer: assert property (axiReq.arvalid && axiRsp.arready |=> axiRsp.rvalid)
    else $error("read data late");
  a_b_single: assert property (axiRsp.bvalid && axiReq.bready |=> !axiRsp.bvalid)
    else $error("write response repeated");
  a_r_single: assert property (axiRsp.rvalid && axiReq.rready |=> !axiRsp.rvalid)
    else $error("read data repeated");
  a_write_refused: assert property (axiRsp.bvalid |-> !axiRsp.awready && !axiRsp.wready)
    else $error("write accepted while response pending");
  a_read_refused: assert property (axiRsp.rvalid |-> !axiRsp.arready)
    else $error("read accepted while data pending");
  a_read_resp: assert property ($rose(axiRsp.rvalid) |-> axiRsp.rresp ==
      (($past(arLow) == 2'h0) ? tcml_pkg::RESP_OKAY : tcml_pkg::RESP_SLVERR))
    else $error("read response code wrong");
  a_flag_clear: assert property ($fell(channelFlag) && !$past(sys_rst)
      |-> axiRsp.bvalid || $past(axiRsp.bvalid))
    else $error("flag dropped without a write");
  a_ext_reset: assert property (extLow |-> !channelOutput)
    else $error("output high under external reset");
endmodule

bind tcml_channel tcml_channel_asserts i_tcml_channel_asserts (
  .mclk          (mclk),
  .sys_rst       (sys_rst),
  .axiReq        (axiReq),
  .axiRsp        (axiRsp),
  .gatePin       (gatePin),
  .countClkPin   (countClkPin),
  .extReset_n    (extReset_n),
  .channelOutput (channelOutput),
  .channelFlag   (channelFlag)
);

/* bench/tcml_pin_src.sv */
`timescale 1ns/1ns
module tcml_pin_src #(
  parameter int HALF = 4
) (
  // Clock
  input  wire logic mclk,
  // Pins toward the channel
  output      logic countClkPin,
  output      logic gatePin
);
  // ******
  // Pin source
  // ******
  // Count clock rests low between bursts
  initial begin
    countClkPin = 1'b0;
    gatePin     = 1'b1;
  end

  // Each high lasts HALF cycles and each low HALF plus one, so the sync flops never miss one
  task automatic tick(input int n);
    repeat (n) begin
      @(posedge mclk);
      countClkPin <= 1'b1;
      repeat (HALF) @(posedge mclk);
      countClkPin <= 1'b0;
      repeat (HALF) @(posedge mclk);
    end
  endtask

  // Gate moves on an edge, then rests until it is acted on
  task automatic setGate(input logic v);
    @(posedge mclk);
    gatePin <= v;
    repeat (6) @(posedge mclk);
  endtask
endmodule

/* bench/tcml_channel_tb.sv */
`timescale 1ns/1ns
module tcml_channel_tb;
  // ******
  // Signals
  // ******
  logic                    mclk;
  logic                    sys_rst;
  tcml_pkg::tcml_axi_req_t axiReq;
  tcml_pkg::tcml_axi_rsp_t axiRsp;
  logic                    gatePin;
  logic                    countClkPin;
  logic                    extReset_n;
  logic                    channelOutput;
  logic                    channelFlag;
  int                      numErrors;
  int                      cmpCount;
  logic [3:0]              strb;
  logic [27:0]             hiAddr;
  localparam logic [31:0] SPL = 32'h1 << tcml_pkg::CTRL_SPLIT_POS;
  localparam logic [31:0] MEA = 32'h1 << tcml_pkg::CTRL_MEASURE_POS;
  localparam logic [31:0] SUB = 32'h1 << tcml_pkg::CTRL_SUB_POS;
  localparam logic [31:0] VAR = 32'h1 << tcml_pkg::CTRL_VARIANT_POS;
  localparam logic [31:0] OEN = 32'h1 << tcml_pkg::CTRL_OUTEN_POS;
  localparam logic [31:0] RST = 32'h1 << tcml_pkg::CTRL_RESET_POS;
  localparam logic [31:0] ALL = 32'hffffffff;
  localparam logic [3:0]  CTL = tcml_pkg::ADDR_CTRL;
  localparam logic [3:0]  PRE = tcml_pkg::ADDR_PRESET;
  localparam logic [3:0]  CNT = tcml_pkg::ADDR_COUNTER;
  localparam logic [3:0]  STA = tcml_pkg::ADDR_STATUS;

  tcml_channel i_tcml_channel (
    .mclk          (mclk),
    .sys_rst       (sys_rst),
    .axiReq        (axiReq),
    .axiRsp        (axiRsp),
    .gatePin       (gatePin),
    .countClkPin   (countClkPin),
    .extReset_n    (extReset_n),
    .channelOutput (channelOutput),
    .channelFlag   (channelFlag)
  );
  tcml_pin_src #(.HALF(4)) i_tcml_pin_src (
    .mclk        (mclk),
    .countClkPin (countClkPin),
    .gatePin     (gatePin)
  );

  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  // ******
  // Shared tasks
  // ******
  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", cmpCount, numErrors);
    if (numErrors == 0 && cmpCount > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmpCount++;
    if (got !== exp) begin
      numErrors++;
      $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask

  // Pins looked at mid-cycle, after the edge's updates have landed
  task automatic pins(input logic [1:0] mask, input logic [1:0] exp);
    @(negedge mclk);
    chk({30'h0, {channelOutput, channelFlag} & mask}, {30'h0, exp});
  endtask

  // One bus transfer; readies sampled mid-cycle, released after the taking edge
  task automatic xfer(input bit w, input logic [3:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic [1:0] r);
    tcml_pkg::tcml_axi_rsp_t s;
    int n;
    n = 0;
    q = 32'h0;
    r = 2'h3;
    @(posedge mclk);
    if (w) begin
      axiReq <= '{awvalid: 1'b1, awaddr: {hiAddr, a}, wvalid: 1'b1, wdata: d,
                  wstrb: strb, bready: 1'b1, default: '0};
    end else begin
      axiReq <= '{arvalid: 1'b1, araddr: {hiAddr, a}, rready: 1'b1, default: '0};
    end
    while (n < 40) begin
      @(negedge mclk);
      s = axiRsp;
      @(posedge mclk);
      if (s.awready) axiReq.awvalid <= 1'b0;
      if (s.wready) axiReq.wvalid <= 1'b0;
      if (s.arready) axiReq.arvalid <= 1'b0;
      if (s.bvalid || s.rvalid) begin
        axiReq.bready <= 1'b0;
        axiReq.rready <= 1'b0;
        q = s.rdata;
        r = w ? s.bresp : s.rresp;
        n = 99;
      end
      n++;
    end
    if (n < 99) begin
      numErrors++;
      conclude();
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic [1:0]  r;
    xfer(1'b1, a, d, q, r);
    chk({30'h0, r}, {30'h0, tcml_pkg::RESP_OKAY});
  endtask

  // Unaligned places answer with an error code and zero data
  task automatic rd(input logic [3:0] a, input logic [31:0] mask, input logic [31:0] exp);
    logic [31:0] q;
    logic [1:0]  r;
    xfer(1'b0, a, 32'h0, q, r);
    chk({30'h0, r}, {30'h0, (a[1:0] == 2'h0) ? tcml_pkg::RESP_OKAY : tcml_pkg::RESP_SLVERR});
    chk(q & mask, exp);
  endtask

  task automatic setup(input logic [31:0] ctl, input logic [31:0] pre);
    wr(CTL, ctl);
    wr(STA, 32'h1);
    wr(PRE, pre);
  endtask

  task automatic tk(input int n);
    i_tcml_pin_src.tick(n);
  endtask

  task automatic gfall();
    i_tcml_pin_src.setGate(1'b1);
    i_tcml_pin_src.setGate(1'b0);
  endtask

  // ******
  // Scenarios
  // ******
  task automatic s_regs();
    rd(CTL, ALL, 32'h0);
    rd(PRE, ALL, 32'h0);
    rd(CNT, ALL, 32'h0);
    rd(STA, 32'hb, 32'h0);
    rd(4'h2, ALL, 32'h0);
    wr(CNT, 32'h1234);
    rd(CNT, ALL, 32'h0);
    // Upper address bits ignored; strobes pick the bytes written
    hiAddr = 28'h5a5a5a5;
    strb   = 4'h1;
    wr(PRE, 32'h1234);
    rd(PRE, ALL, 32'h0034);
    rd(CNT, ALL, 32'h0034);
    strb   = 4'h2;
    wr(PRE, 32'h5600);
    wr(CTL, ALL);
    rd(PRE, ALL, 32'h5634);
    rd(CTL, ALL, 32'h0);
    strb   = 4'hf;
  endtask

  task automatic s_dual();
    i_tcml_pin_src.setGate(1'b0);
    setup(SPL | OEN, 32'h0203);
    tk(3);
    rd(CNT, ALL, 32'h0200);
    tk(1);
    rd(CNT, ALL, 32'h0103);
    tk(4);
    pins(2'b11, 2'b00);
    tk(1);
    pins(2'b11, 2'b10);
    tk(3);
    pins(2'b11, 2'b01);
    rd(CNT, ALL, 32'h0203);
    wr(CTL, SPL | SUB | OEN);
    wr(PRE, 32'h0505);
    rd(CNT, ALL, 32'h0203);
  endtask

  task automatic s_dual_zero(input logic en);
    setup(SPL | (en ? OEN : 32'h0), 32'h0200);
    tk(2);
    rd(CNT, ALL, 32'h0000);
    tk(1);
    pins(2'b11, {en, 1'b1});
    rd(CNT, ALL, 32'h0200);
    tk(3);
    pins(2'b11, 2'b01);
  endtask

  task automatic s_both_zero();
    setup(OEN, 32'h0002);
    tk(3);
    pins(2'b11, 2'b11);
    setup(SPL | OEN, 32'h0);
    tk(1);
    pins(2'b10, 2'b10);
    tk(1);
    pins(2'b10, 2'b00);
    rd(CNT, ALL, 32'h0);
    tk(1);
    @(posedge mclk);
    extReset_n <= 1'b0;
    repeat (8) @(posedge mclk);
    pins(2'b10, 2'b00);
    @(posedge mclk);
    extReset_n <= 1'b1;
    repeat (4) @(posedge mclk);
    tk(1);
    pins(2'b10, 2'b10);
    wr(CTL, SPL | OEN | RST);
    repeat (3) @(posedge mclk);
    pins(2'b10, 2'b00);
  endtask

  task automatic s_shot();
    i_tcml_pin_src.setGate(1'b1);
    setup(VAR | OEN, 32'h0003);
    tk(2);
    pins(2'b11, 2'b10);
    tk(2);
    pins(2'b11, 2'b01);
    rd(CNT, ALL, 32'h0003);
    wr(STA, 32'h1);
    tk(4);
    pins(2'b11, 2'b01);
    setup(VAR | OEN, 32'h0);
    tk(1);
    pins(2'b11, 2'b01);
    wr(STA, 32'h1);
    tk(1);
    pins(2'b11, 2'b01);
  endtask

  task automatic s_freq0();
    setup(MEA | OEN, 32'h0005);
    gfall();
    tk(2);
    rd(CNT, ALL, 32'h0003);
    gfall();
    pins(2'b01, 2'b01);
    wr(STA, 32'h1);
    gfall();
    tk(7);
    rd(STA, 32'h9, 32'h8);
    gfall();
    pins(2'b01, 2'b00);
  endtask

  task automatic s_freq1();
    setup(MEA | VAR | OEN, 32'h0005);
    gfall();
    tk(2);
    gfall();
    pins(2'b01, 2'b00);
    rd(CNT, ALL, 32'h0005);
    tk(6);
    pins(2'b11, 2'b11);
    rd(STA, 32'h4, 32'h0);
    wr(CTL, MEA | VAR | OEN | RST);
    rd(STA, 32'h8, 32'h0);
  endtask

  task automatic s_pulse();
    setup(MEA | SUB | OEN, 32'h0005);
    gfall();
    tk(2);
    i_tcml_pin_src.setGate(1'b1);
    pins(2'b01, 2'b01);
    setup(MEA | SUB | VAR | OEN, 32'h0005);
    gfall();
    tk(2);
    i_tcml_pin_src.setGate(1'b1);
    pins(2'b01, 2'b00);
    gfall();
    tk(6);
    pins(2'b01, 2'b01);
  endtask

  // ******
  // Main sequence
  // ******
  initial begin
    sys_rst    = 1'b1;
    extReset_n = 1'b1;
    axiReq     = '0;
    numErrors  = 0;
    cmpCount   = 0;
    strb       = 4'hf;
    hiAddr     = 28'h0;
    repeat (12) @(posedge mclk);
    sys_rst <= 1'b0;
    s_regs();
    s_dual();
    s_dual_zero(1'b1);
    s_dual_zero(1'b0);
    s_both_zero();
    s_shot();
    s_freq0();
    s_freq1();
    s_pulse();
    conclude();
  end
endmodule
